// ===== inc/dpr_pkg.sv
// Shared constants and types for the DDR2 precharge, refresh and power-down block
package dpr_pkg;
	localparam int NUM_BANKS = 4;
	localparam int BA_W      = 2;
	localparam int A10_BIT   = 10;
	localparam int ADDR_W    = 14;
	localparam int CLK_PERIOD_PS = 5000;
	// Command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_ACT  = 4'h3;
	localparam logic [3:0] CMD_PRE  = 4'h2;
	localparam logic [3:0] CMD_REF  = 4'h1;
	localparam logic [3:0] CMD_MRS  = 4'h0;
	localparam logic [3:0] CMD_RD   = 4'h5;
	localparam logic [3:0] CMD_WR   = 4'h4;
	localparam logic [3:0] CMD_NOP  = 4'h7;
	// Timing, in their own units, and derived cycle counts
	localparam int TRFC_NS   = 105;
	localparam int TRFC_CYC  = (TRFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TXSNR_NS  = 115;
	localparam int TXSNR_CYC = (TXSNR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TXSRD_CYC = 200;
	localparam int TCKE_CYC  = 3;
	localparam int CNT_W     = 8;
	typedef enum logic [2:0]
	{
		ST_IDLE_ACT,
		ST_SREF,
		ST_SREF_EXIT,
		ST_PD_PRE,
		ST_PD_ACT
	} dpr_state_type;
endpackage : dpr_pkg

// ===== verilog/dpr_down_counter.sv
// Loadable down counter with a zero flag
`timescale 1ns/1ps
module dpr_down_counter
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] value,
	output logic                  zero
);
	typedef struct packed
	{
		logic [WIDTH-1:0] cnt;
	} dpr_cnt_type;
	dpr_cnt_type st_r;
	dpr_cnt_type st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		if (load)
			st_nxt.cnt = value;
		else if (st_r.cnt != '0)
			st_nxt.cnt = st_r.cnt - 1'b1;
	end
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign zero = (st_r.cnt == '0);
endmodule : dpr_down_counter

// ===== verilog/dpr_ctrl.sv
// Bank state, refresh and power-down control of a four-bank DDR2 device
// Contract
// [R1] Precharge closes rows, explicit or auto
// [R2] A10 high precharges all banks
// [R3] Precharged bank needs ACTIVATE before access
// [R4] Controller waits tRP or tRPA after precharge
// [R5] REFRESH spaced 7.8125us average at most
// [R6] Refresh busy for tRFC after command
// [R7] Close all banks before REFRESH
// [R8] REFRESH with CKE low enters self refresh
// [R9] All idle, ODT off before self refresh
// [R10] Clock stable around self refresh edges
// [R11] Only NOP until tXSNR after exit
// [R12] No READ before tXSRD 200 clocks
// [R13] Exit intervals counted from first CKE-high edge
// [R14] CKE high until tXSRD unless re-entering; code flags CKE low only before tXSNR
// [R15] ODT low until tXSRD after exit
// [R16] CKE high from access to burst end
// [R17] Burst completion includes postamble, tWR/tWTR
// [R18] CKE low with NOP enters power-down
// [R19] Idle banks give precharge power-down
// [R20] Buffers off in power-down, DLL frozen; code freezes the DLL only in precharge power-down
// [R21] Active power-down keeps clock frequency
// [R22] CKE high with NOP exits power-down
// [R23] CKE level held three clocks
// [R24] No refresh during power-down
// [R25] Self refresh only from all idle
// [R26] Controller tracks per-bank open state
`timescale 1ns/1ps
module dpr_ctrl
(
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	input  wire logic                          cke,
	input  wire logic                          cs_n,
	input  wire logic                          ras_n,
	input  wire logic                          cas_n,
	input  wire logic                          we_n,
	input  wire logic [dpr_pkg::BA_W-1:0]      bank_addr,
	input  wire logic [dpr_pkg::ADDR_W-1:0]    addr,
	output logic      [dpr_pkg::NUM_BANKS-1:0] bank_open,
	output logic                               refresh_busy,
	output logic                               self_refresh,
	output logic                               pd_precharge,
	output logic                               pd_active,
	output logic                               buffers_on,
	output logic                               dll_frozen,
	output logic                               nonread_ok,
	output logic                               read_ok,
	output logic                               cmd_error
);
	typedef struct packed
	{
		logic [3:0]                     cmd_s1;
		logic [3:0]                     cmd_s2;
		logic                           cke_s1;
		logic                           cke_s2;
		logic                           cke_prev;
		logic [dpr_pkg::BA_W-1:0]       ba_s1;
		logic [dpr_pkg::BA_W-1:0]       ba_s2;
		logic                           a10_s1;
		logic                           a10_s2;
		dpr_pkg::dpr_state_type         state;
		logic [dpr_pkg::NUM_BANKS-1:0]  open;
		logic [dpr_pkg::NUM_BANKS-1:0]  ap_pend;
		logic                           busy;
		logic                           err;
		logic                           nonread_ok;
		logic                           read_ok;
	} dpr_ctrl_type;

	dpr_ctrl_type st_r;
	dpr_ctrl_type st_nxt;
	logic         rfc_load;
	logic         rfc_zero;
	logic         xsnr_load;
	logic         xsnr_zero;
	logic         xsrd_zero;
	logic [3:0]   cmd;
	logic         is_nop;

	// Pins pass two flops; command and CKE sampled together so they stay aligned
	assign cmd    = st_r.cmd_s2;
	assign is_nop = (cmd == dpr_pkg::CMD_NOP) || st_r.cmd_s2[3];

	dpr_down_counter #(.WIDTH(dpr_pkg::CNT_W)) u_rfc
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (rfc_load),
		.value   (dpr_pkg::CNT_W'(dpr_pkg::TRFC_CYC - 1)),
		.zero    (rfc_zero)
	);

	dpr_down_counter #(.WIDTH(dpr_pkg::CNT_W)) u_xsnr
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (xsnr_load),
		.value   (dpr_pkg::CNT_W'(dpr_pkg::TXSNR_CYC - 1)),
		.zero    (xsnr_zero)
	);

	dpr_down_counter #(.WIDTH(dpr_pkg::CNT_W)) u_xsrd
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (xsnr_load),
		.value   (dpr_pkg::CNT_W'(dpr_pkg::TXSRD_CYC - 1)),
		.zero    (xsrd_zero)
	);

	always_comb
	begin
		st_nxt          = st_r;
		rfc_load        = 1'b0;
		xsnr_load       = 1'b0;
		st_nxt.cmd_s1   = {cs_n, ras_n, cas_n, we_n};
		st_nxt.cmd_s2   = st_r.cmd_s1;
		st_nxt.cke_s1   = cke;
		st_nxt.cke_s2   = st_r.cke_s1;
		st_nxt.cke_prev = st_r.cke_s2;
		st_nxt.ba_s1    = bank_addr;
		st_nxt.ba_s2    = st_r.ba_s1;
		st_nxt.a10_s1   = addr[dpr_pkg::A10_BIT];
		st_nxt.a10_s2   = st_r.a10_s1;
		st_nxt.busy     = st_r.busy && !rfc_zero;
		st_nxt.err      = 1'b0;
		case (st_r.state)
			dpr_pkg::ST_IDLE_ACT:
			begin
				if (st_r.cke_prev && st_r.cke_s2 && !st_r.cmd_s2[3])
				begin
					case (cmd)
						dpr_pkg::CMD_ACT:
							st_nxt.open[st_r.ba_s2] = 1'b1;
						dpr_pkg::CMD_PRE:
							if (st_r.a10_s2)
								st_nxt.open = '0; // [R1] [R2]
							else
								st_nxt.open[st_r.ba_s2] = 1'b0; // [R1] [R2]
						dpr_pkg::CMD_RD, dpr_pkg::CMD_WR:
						begin
							if (!st_r.open[st_r.ba_s2] || (cmd == dpr_pkg::CMD_RD && !st_r.read_ok))
								st_nxt.err = 1'b1; // [R3] [R12]
							if (st_r.a10_s2)
								st_nxt.ap_pend[st_r.ba_s2] = 1'b1; // [R1]
						end
						dpr_pkg::CMD_REF:
						begin
							if (st_r.open != '0)
								st_nxt.err = 1'b1; // [R7]
							st_nxt.busy = 1'b1; // [R6]
							rfc_load    = 1'b1; // [R6]
						end
						default:
							st_nxt.err = 1'b0;
					endcase
					if (!st_r.nonread_ok && cmd != dpr_pkg::CMD_RD)
						st_nxt.err = 1'b1; // [R11]
				end
				else if (st_r.cke_prev && !st_r.cke_s2)
				begin
					if (cmd == dpr_pkg::CMD_REF && !st_r.cmd_s2[3])
					begin
						if (st_r.open != '0)
							st_nxt.err = 1'b1; // [R25] [R9]
						st_nxt.state      = dpr_pkg::ST_SREF; // [R8]
						st_nxt.nonread_ok = 1'b0;
						st_nxt.read_ok    = 1'b0;
					end
					else if (is_nop)
					begin
						// Auto-precharges still pending are folded in before choosing the mode
						st_nxt.open = st_r.open & ~st_r.ap_pend;
						if ((st_r.open & ~st_r.ap_pend) == '0)
							st_nxt.state = dpr_pkg::ST_PD_PRE; // [R18] [R19]
						else
							st_nxt.state = dpr_pkg::ST_PD_ACT; // [R18] [R19]
						st_nxt.ap_pend = '0;
					end
					else
						st_nxt.err = 1'b1; // [R18]
				end
				// Auto-precharge retires at the next idle command slot
				if (cmd != dpr_pkg::CMD_RD && cmd != dpr_pkg::CMD_WR && st_r.ap_pend != '0)
				begin
					st_nxt.open    = st_nxt.open & ~st_r.ap_pend; // [R1]
					st_nxt.ap_pend = '0;
				end
			end
			dpr_pkg::ST_SREF:
			begin
				// Internal refresh keeps the busy flag off the bus
				st_nxt.busy = 1'b0;
				if (st_r.cke_s2)
				begin
					if (!is_nop)
						st_nxt.err = 1'b1;
					st_nxt.state = dpr_pkg::ST_SREF_EXIT; // [R13]
					xsnr_load    = 1'b1; // [R13]
				end
			end
			dpr_pkg::ST_SREF_EXIT:
			begin
				if (!xsnr_zero && !is_nop)
					st_nxt.err = 1'b1; // [R11]
				// A read here would leave this state undecoded, so flag it now
				if (cmd == dpr_pkg::CMD_RD && !st_r.cmd_s2[3] && !xsrd_zero)
					st_nxt.err = 1'b1; // [R12]
				if (!st_r.cke_s2)
				begin
					if (!xsnr_zero)
						st_nxt.err = 1'b1; // [R14]
					if (cmd == dpr_pkg::CMD_REF && !st_r.cmd_s2[3])
						st_nxt.state = dpr_pkg::ST_SREF; // [R14]
				end
				else if (xsnr_zero && !is_nop)
					st_nxt.state = dpr_pkg::ST_IDLE_ACT;
				else if (xsrd_zero)
					st_nxt.state = dpr_pkg::ST_IDLE_ACT;
			end
			dpr_pkg::ST_PD_PRE, dpr_pkg::ST_PD_ACT:
			begin
				// No refresh runs here; controller bounds the stay
				if (st_r.cke_s2)
				begin
					if (!is_nop)
						st_nxt.err = 1'b1; // [R22]
					st_nxt.state = dpr_pkg::ST_IDLE_ACT; // [R22] [R24]
				end
			end
			default:
				st_nxt.state = dpr_pkg::ST_IDLE_ACT;
		endcase
		// Windows track their counters in every state but ST_SREF, so an early exit still opens them
		if (st_nxt.state == dpr_pkg::ST_SREF || xsnr_load)
		begin
			st_nxt.nonread_ok = 1'b0;
			st_nxt.read_ok    = 1'b0;
		end
		else
		begin
			st_nxt.nonread_ok = xsnr_zero; // [R11] [R13]
			st_nxt.read_ok    = xsrd_zero; // [R12] [R13]
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_r            <= '0;
			st_r.cmd_s1     <= dpr_pkg::CMD_NOP;
			st_r.cmd_s2     <= dpr_pkg::CMD_NOP;
			st_r.cke_s1     <= 1'b1;
			st_r.cke_s2     <= 1'b1;
			st_r.cke_prev   <= 1'b1;
			st_r.state      <= dpr_pkg::ST_IDLE_ACT;
			st_r.nonread_ok <= 1'b1;
			st_r.read_ok    <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign bank_open    = st_r.open; // [R26]
	assign refresh_busy = st_r.busy; // [R6]
	assign self_refresh = (st_r.state == dpr_pkg::ST_SREF);
	assign pd_precharge = (st_r.state == dpr_pkg::ST_PD_PRE);
	assign pd_active    = (st_r.state == dpr_pkg::ST_PD_ACT);
	assign buffers_on   = (st_r.state == dpr_pkg::ST_IDLE_ACT) || (st_r.state == dpr_pkg::ST_SREF_EXIT); // [R20]
	assign dll_frozen   = (st_r.state == dpr_pkg::ST_PD_PRE) || (st_r.state == dpr_pkg::ST_SREF); // [R20]
	assign nonread_ok   = st_r.nonread_ok;
	assign read_ok      = st_r.read_ok;
	assign cmd_error    = st_r.err;
endmodule : dpr_ctrl

// ===== test/dpr_ctrl_props.sv
// Port-level checks of bank, refresh and power-down behaviour
`timescale 1ns/1ps
module dpr_ctrl_props
(
	input wire logic                          clk_sys,
	input wire logic                          rst,
	input wire logic                          cke,
	input wire logic                          cs_n,
	input wire logic                          ras_n,
	input wire logic                          cas_n,
	input wire logic                          we_n,
	input wire logic [dpr_pkg::ADDR_W-1:0]    addr,
	input wire logic [dpr_pkg::NUM_BANKS-1:0] bank_open,
	input wire logic                          refresh_busy,
	input wire logic                          self_refresh,
	input wire logic                          pd_precharge,
	input wire logic                          pd_active,
	input wire logic                          buffers_on,
	input wire logic                          dll_frozen,
	input wire logic                          nonread_ok,
	input wire logic                          read_ok
);
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Window of 3 to 4 edges covers the two-flop input pipeline
	chk_pre_all: assert property (cmd == dpr_pkg::CMD_PRE && addr[dpr_pkg::A10_BIT] && cke && $past(cke)
		|-> ##[3:4] bank_open == 4'h0) else $error("precharge all left a bank open");
	chk_ref_busy: assert property (cmd == dpr_pkg::CMD_REF && cke && $past(cke)
		|-> ##[3:4] refresh_busy) else $error("refresh busy not raised");
	chk_busy_len: assert property ($fell(refresh_busy) |-> $past(refresh_busy, 20))
		else $error("refresh busy too short");
	chk_sref_entry: assert property (cmd == dpr_pkg::CMD_REF && !cke && $past(cke)
		|-> ##[3:4] self_refresh && !read_ok) else $error("self refresh not entered");
	chk_pd_entry: assert property ($fell(cke) && cmd == dpr_pkg::CMD_NOP
		|-> ##[3:4] pd_precharge || pd_active) else $error("power-down not entered");
	chk_pd_idle: assert property (pd_precharge |-> bank_open == 4'h0 && !buffers_on && dll_frozen)
		else $error("precharge power-down state wrong");
	chk_pd_open: assert property (pd_active |-> bank_open != 4'h0 && !buffers_on && !dll_frozen)
		else $error("active power-down state wrong");
	chk_pd_exit: assert property ($rose(cke) && cmd == dpr_pkg::CMD_NOP
		|-> ##[3:4] !pd_precharge && !pd_active) else $error("power-down not left");
	chk_nonread_wait: assert property ($rose(nonread_ok) |-> !$past(nonread_ok, 20) && !read_ok)
		else $error("nonread allowed too early");
	chk_read_wait: assert property ($rose(read_ok) |-> !$past(read_ok, 190))
		else $error("read allowed too early");
endmodule : dpr_ctrl_props
bind dpr_ctrl dpr_ctrl_props i_props (.*);

// ===== test/dpr_host_model.sv
// Controller-side model driving command pins and CKE
`timescale 1ns/1ps
module dpr_host_model
(
	input  wire logic                       clk_sys,
	output logic                            cke,
	output logic                            cs_n,
	output logic                            ras_n,
	output logic                            cas_n,
	output logic                            we_n,
	output logic [dpr_pkg::BA_W-1:0]        bank_addr,
	output logic [dpr_pkg::ADDR_W-1:0]      addr
);
	initial
	begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = dpr_pkg::CMD_NOP;
		bank_addr = 2'h0;
		addr = 14'h0000;
	end
	// ODT has no pin here; it stays low throughout, so it is off at every entry
	// Refreshes come close together, well inside the average spacing
	// One command slot, then NOP with scrambled address lines
	task issue(input logic [3:0] c, input logic [1:0] ba, input logic a10, input logic k);
		@(negedge clk_sys);
		{cs_n, ras_n, cas_n, we_n} = c;
		bank_addr = ba;
		addr = 14'h0000;
		addr[dpr_pkg::A10_BIT] = a10;
		cke = k;
		@(negedge clk_sys);
		{cs_n, ras_n, cas_n, we_n} = dpr_pkg::CMD_NOP;
		bank_addr = ~bank_addr;
		addr = ~addr;
		repeat (3) @(negedge clk_sys);
	endtask : issue
endmodule : dpr_host_model

// ===== test/dpr_ctrl_tb.sv
// Self-checking bench for bank, refresh and power-down control
`timescale 1ns/1ps
module dpr_ctrl_tb;
	logic                          clk_sys;
	logic                          rst;
	logic                          cke, cs_n, ras_n, cas_n, we_n;
	logic [dpr_pkg::BA_W-1:0]      bank_addr;
	logic [dpr_pkg::ADDR_W-1:0]    addr;
	logic [dpr_pkg::NUM_BANKS-1:0] bank_open;
	logic                          refresh_busy, self_refresh, pd_precharge, pd_active;
	logic                          buffers_on, dll_frozen, nonread_ok, read_ok, cmd_error;
	logic                          err_seen = 1'b0;
	int                            failures, checks_done, cyc, t0;
	dpr_host_model i_host (.*);
	dpr_ctrl i_dut (.*);
	initial
	begin
		clk_sys = 1'b0;
		// Free-running, one fixed period throughout
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;
	always @(posedge clk_sys) if (cmd_error === 1'b1) err_seen <= 1'b1;
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task settle;
		repeat (2) @(negedge clk_sys);
	endtask : settle
	task t_banks;
		for (int b = 0; b < 4; b++) i_host.issue(dpr_pkg::CMD_ACT, 2'(b), 1'b0, 1'b1);
		settle();
		check("open all", 32'(bank_open), 32'h0f);
		i_host.issue(dpr_pkg::CMD_PRE, 2'h2, 1'b0, 1'b1);
		settle();
		check("close one", 32'(bank_open), 32'h0b);
		i_host.issue(dpr_pkg::CMD_PRE, 2'h1, 1'b1, 1'b1);
		settle();
		check("close all", 32'(bank_open), 32'h00);
	endtask : t_banks
	task t_refresh;
		i_host.issue(dpr_pkg::CMD_REF, 2'h0, 1'b0, 1'b1);
		settle();
		check("busy", 32'(refresh_busy), 32'h1);
		repeat (dpr_pkg::TRFC_CYC) @(negedge clk_sys);
		check("busy end", 32'(refresh_busy), 32'h0);
	endtask : t_refresh
	task t_pd;
		i_host.issue(dpr_pkg::CMD_ACT, 2'h1, 1'b0, 1'b1);
		i_host.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
		settle();
		check("pd active", 32'(pd_active), 32'h1);
		check("buffers", 32'(buffers_on), 32'h0);
		check("dll act", 32'(dll_frozen), 32'h0);
		i_host.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
		settle();
		check("pd act exit", 32'(pd_active), 32'h0);
		i_host.issue(dpr_pkg::CMD_PRE, 2'h0, 1'b1, 1'b1);
		i_host.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
		settle();
		check("pd pre", 32'(pd_precharge), 32'h1);
		check("dll pre", 32'(dll_frozen), 32'h1);
		i_host.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
		settle();
		check("pd pre exit", 32'(pd_precharge), 32'h0);
		check("no error", 32'(err_seen), 32'h0);
	endtask : t_pd
	task t_sref;
		i_host.issue(dpr_pkg::CMD_REF, 2'h0, 1'b0, 1'b0);
		settle();
		check("sref", 32'(self_refresh), 32'h1);
		check("read gate", 32'(read_ok), 32'h0);
		t0 = cyc;
		i_host.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
		for (int i = 0; i < 400 && nonread_ok !== 1'b1; i++) @(negedge clk_sys);
		check("nonread wait", 32'(cyc - t0 >= dpr_pkg::TXSNR_CYC), 32'h1);
		// Deliberate early read to a closed bank must be flagged
		i_host.issue(dpr_pkg::CMD_RD, 2'h0, 1'b0, 1'b1);
		settle();
		check("early read", 32'(err_seen), 32'h1);
		for (int i = 0; i < 400 && read_ok !== 1'b1; i++) @(negedge clk_sys);
		check("read wait", 32'(cyc - t0 >= dpr_pkg::TXSRD_CYC && read_ok === 1'b1), 32'h1);
	endtask : t_sref
	task end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	initial
	begin
		rst = 1'b1;
		cyc = 0;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		t_banks();
		t_refresh();
		t_pd();
		t_sref();
		end_of_test();
	end
	initial
	begin
		#50000;
		failures++;
		end_of_test();
	end
endmodule : dpr_ctrl_tb
